// *** hw/dft_monitor.sv ***
// Drive fault and trip monitor: external trip, overload and command loss.
`timescale 1ns/1ps
// Behaviour
// - A terminal whose function code is 4 acts as external trip input.
// - Normally-open trip terminal closing flags a fault, forces output off.
// - Normally-closed trip terminal opening flags a fault, forces output off.
// - Terminals one to five map to bits zero to four.
// - Current above rated fills an inverse-time accumulator which trips overload.
// - A warning output rises before the overload trip level is reached.
// - Criterion 1 declares loss below half the minimum input value.
// - Criterion 2 declares loss below the minimum; criterion 0 disables voltage and current loss, not communication loss.
// - Loss detection covers voltage, current and communication sources.
// - Post-loss mode 1 blocks output on confirmed loss.
// - Post-loss mode 2 decelerates to stop on confirmed loss.
// - Loss is confirmed only after no command over a wait time's count of free-running loss-unit ticks.
// - Relay function code 11 shows speed command loss on the relay.
// - Communication loss acts only after the wait time has elapsed.
module dft_monitor
#(
  parameter int TICK_MS_CYC = dft_pkg::OL_TICK_CYC,
  parameter int TICK_DS_CYC = dft_pkg::LOSS_UNIT_CYC
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  // Field side
  input  wire logic [4:0]  digital_in,
  input  wire logic [11:0] volt_input,
  input  wire logic [11:0] current_input,
  input  wire logic [11:0] drive_current,
  input  wire logic        comm_cmd_present,
  // Output stage and relay
  output logic             output_off,
  output logic             decel_stop,
  output logic             relay_out,
  output logic             warn_out,
  output logic             irq
);
  import dft_pkg::*;

  function automatic logic [4:0] func_of(input logic [24:0] codes, input int idx);
    func_of = codes[idx*FUNC_W +: FUNC_W];
  endfunction

  dft_state_t st;
  dft_state_t next_st;

  logic [4:0]  term_trip;
  logic        ext_cond;
  logic        raw_loss;
  logic [1:0]  crit;
  logic [1:0]  mode;
  logic [1:0]  src;
  logic [4:0]  relay_func;
  logic [15:0] ol_hi;
  logic        ms_tick;
  logic        ds_tick;
  logic        fault_rst;
  logic        ana_low;
  logic [11:0] ana_val;
  logic [11:0] ana_min;

  assign crit       = st.loss_cfg[CRIT_LSB +: 2];
  assign mode       = st.loss_cfg[MODE_LSB +: 2];
  assign relay_func = st.loss_cfg[RELAY_LSB +: 5];
  assign src        = st.loss_cfg[SRC_LSB +: 2];
  assign ol_hi      = st.ol_acc[23:8];
  assign ms_tick    = (st.ms_cnt == 23'(TICK_MS_CYC - 1));
  assign ds_tick    = (st.ds_cnt == 23'(TICK_DS_CYC - 1));
  assign fault_rst  = wr_en && (addr == REG_CTRL) && wr_data[CTRL_FRST];

  // ==========================================================================
  // External trip terminals
  // Bit per terminal.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_term
      assign term_trip[gi] = (func_of(st.in_func, gi) == FUNC_EXT_TRIP) && (digital_in[gi] ^ st.nc_sel[gi]);
    end
  endgenerate
  assign ext_cond = |term_trip;

  // ==========================================================================
  // Command loss detection
  assign ana_val = (src == SRC_CURRENT) ? current_input : volt_input;
  assign ana_min = (src == SRC_CURRENT) ? st.imin : st.vmin;
  assign ana_low = (crit == CRIT_HALF)  ? (ana_val < {1'b0, ana_min[11:1]}) :
                   (crit == CRIT_BELOW) ? (ana_val < ana_min) : 1'b0;
  assign raw_loss = (src == SRC_VOLT || src == SRC_CURRENT) ? ana_low :
                    (src == SRC_COMM) ? !comm_cmd_present : 1'b0;

  always_comb
  begin
    logic [11:0] excess;
    logic [24:0] sum;
    logic [31:0] rd_mux;
    logic [3:0]  ev;
    next_st = st;
    excess  = 12'h000;
    sum     = 25'h0000000;
    rd_mux  = 32'h00000000;
    ev      = 4'h0;
    next_st.ms_cnt = ms_tick ? 23'h000000 : st.ms_cnt + 23'h000001;
    next_st.ds_cnt = ds_tick ? 23'h000000 : st.ds_cnt + 23'h000001;

    // Register writes.
    if (wr_en)
    begin
      unique case (addr)
        REG_IN_FUNC:   next_st.in_func   = wr_data[24:0];
        REG_CONTACT:   next_st.nc_sel    = wr_data[4:0];
        REG_LOSS_CFG:  next_st.loss_cfg  = wr_data[10:0];
        REG_WAIT_TIME: next_st.wait_time = wr_data[10:0];
        REG_IN_MIN:
        begin
          next_st.vmin = wr_data[11:0];
          next_st.imin = wr_data[IMIN_LSB +: 12];
        end
        REG_RATED:     next_st.rated     = wr_data[11:0];
        REG_OL_LIMIT:
        begin
          next_st.trip_lim = wr_data[15:0];
          next_st.warn_lim = wr_data[WARN_LSB +: 16];
        end
        REG_IRQ_MASK:  next_st.irq_mask  = wr_data[3:0];
        default:       ;
      endcase
    end

    // Inverse-time accumulation: larger excess fills faster.
    if (ms_tick)
    begin
      if (drive_current > st.rated)
      begin
        excess = drive_current - st.rated;
        sum    = {1'b0, st.ol_acc} + {13'h0000, excess};
        next_st.ol_acc = sum[24] ? 24'hffffff : sum[23:0];
      end
      else
      begin
        excess = st.rated - drive_current;
        next_st.ol_acc = (st.ol_acc > {12'h000, excess}) ? st.ol_acc - {12'h000, excess} : 24'h000000;
      end
    end

    // Trips latch; a still-present cause wins over the reset.
    next_st.ext_trip = ext_cond || (st.ext_trip && !fault_rst);
    next_st.ol_trip  = (ol_hi >= st.trip_lim) || (st.ol_trip && !fault_rst);
    next_st.warn_out = (ol_hi >= st.warn_lim);

    // Wait-time qualification, restarted whenever a command returns.
    if (!raw_loss)
    begin
      next_st.loss_cnt  = 11'h000;
      next_st.loss_conf = 1'b0;
    end
    else
    begin
      if (ds_tick && st.loss_cnt < st.wait_time)
        next_st.loss_cnt = st.loss_cnt + 11'h001;
      next_st.loss_conf = (st.loss_cnt >= st.wait_time) && (st.loss_cnt != 11'h000);
    end

    next_st.output_off = next_st.ext_trip || next_st.ol_trip || (next_st.loss_conf && mode == MODE_FREE_RUN);
    next_st.decel_stop = next_st.loss_conf && (mode == MODE_DECEL);
    next_st.relay_out  = next_st.loss_conf && (relay_func == RELAY_CMD_LOSS);

    // Sticky interrupt events; a set in the clearing cycle survives.
    ev[IRQ_EXT]  = next_st.ext_trip && !st.ext_trip;
    ev[IRQ_OL]   = next_st.ol_trip && !st.ol_trip;
    ev[IRQ_WARN] = next_st.warn_out && !st.warn_out;
    ev[IRQ_LOSS] = next_st.loss_conf && !st.loss_conf;
    next_st.irq_stat = st.irq_stat;
    if (wr_en && addr == REG_IRQ_STAT)
      next_st.irq_stat = st.irq_stat & ~wr_data[3:0];
    next_st.irq_stat = next_st.irq_stat | ev;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

    // Read data stand only in the cycle after the strobe.
    unique case (addr)
      REG_IN_FUNC:   rd_mux = {7'h00, st.in_func};
      REG_CONTACT:   rd_mux = {27'h0000000, st.nc_sel};
      REG_LOSS_CFG:  rd_mux = {21'h000000, st.loss_cfg};
      REG_WAIT_TIME: rd_mux = {21'h000000, st.wait_time};
      REG_IN_MIN:    rd_mux = {4'h0, st.imin, 4'h0, st.vmin};
      REG_RATED:     rd_mux = {20'h00000, st.rated};
      REG_OL_LIMIT:  rd_mux = {st.warn_lim, st.trip_lim};
      REG_STATUS:    rd_mux = {19'h00000, digital_in, 2'h0, st.loss_conf, raw_loss,
                               st.warn_out, st.ol_trip, st.ext_trip, st.output_off};
      REG_IRQ_STAT:  rd_mux = {28'h0000000, st.irq_stat};
      REG_IRQ_MASK:  rd_mux = {28'h0000000, st.irq_mask};
      default:       rd_mux = 32'h00000000;
    endcase
    next_st.rd_data = rd_en ? rd_mux : 32'h00000000;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st           <= '0;
      st.in_func   <= RST_IN_FUNC;
      st.nc_sel    <= RST_CONTACT;
      st.loss_cfg  <= RST_LOSS_CFG;
      st.wait_time <= RST_WAIT_TIME;
      st.vmin      <= RST_IN_MIN;
      st.imin      <= RST_IN_MIN;
      st.rated     <= RST_RATED;
      st.trip_lim  <= RST_TRIP_LIM;
      st.warn_lim  <= RST_WARN_LIM;
      st.irq_mask  <= RST_IRQ_MASK;
    end
    else
      st <= next_st;
  end

  assign rd_data    = st.rd_data;
  assign output_off = st.output_off;
  assign decel_stop = st.decel_stop;
  assign relay_out  = st.relay_out;
  assign warn_out   = st.warn_out;
  assign irq        = st.irq;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_ext_seen;
    ext_cond ##1 st.ext_trip;
  endsequence
  sequence s_loss_confirmed;
    raw_loss && st.loss_cnt >= st.wait_time && st.loss_cnt != 11'h000 ##1 st.loss_conf;
  endsequence

  AST_EXT_TRIP: assert property (ext_cond |-> s_ext_seen ##0 output_off)
    else $error("external trip cause did not force output off");
  AST_EXT_NO: assert property (func_of(st.in_func, 3) == FUNC_EXT_TRIP && !st.nc_sel[3] && digital_in[3]
                               |=> st.ext_trip)
    else $error("normally-open trip contact closing missed");
  AST_EXT_NC: assert property (func_of(st.in_func, 4) == FUNC_EXT_TRIP && st.nc_sel[4] && !digital_in[4]
                               |=> output_off)
    else $error("normally-closed trip contact opening missed");
  AST_LATCH: assert property (st.ext_trip && !fault_rst |=> st.ext_trip && output_off)
    else $error("trip latch released without fault reset");
  AST_OL_TRIP: assert property (ol_hi >= st.trip_lim |=> st.ol_trip ##0 output_off)
    else $error("overload level reached without trip");
  AST_WARN: assert property ($rose(st.ol_trip) && st.warn_lim < st.trip_lim |-> warn_out || $past(warn_out))
    else $error("overload trip without prior warning");
  AST_CRIT_OFF: assert property (crit == CRIT_OFF && src != SRC_COMM |-> !raw_loss)
    else $error("loss declared with detection disabled");
  AST_CRIT_HALF: assert property (crit == CRIT_HALF && src == SRC_VOLT && volt_input < {1'b0, st.vmin[11:1]}
                                  |-> raw_loss)
    else $error("half-minimum loss not declared");
  AST_WAIT: assert property ($rose(st.loss_conf) |-> $past(st.loss_cnt) >= $past(st.wait_time))
    else $error("loss confirmed before wait time");
  AST_COMM: assert property (src == SRC_COMM && !comm_cmd_present && st.loss_cnt < st.wait_time
                             |=> !st.loss_conf)
    else $error("communication loss acted early");
  AST_CONFIRM: assert property (s_loss_confirmed |-> st.relay_out == (relay_func == RELAY_CMD_LOSS))
    else $error("relay does not show command loss");
  AST_FREE_RUN: assert property (st.loss_conf && mode == MODE_FREE_RUN |-> output_off)
    else $error("free run mode did not block output");
  AST_DECEL: assert property (st.loss_conf && mode == MODE_DECEL |-> decel_stop)
    else $error("decel mode did not request stop");
  AST_RUN: assert property (st.loss_conf && mode == MODE_RUN && !st.ext_trip && !st.ol_trip
                            |-> !output_off && !decel_stop)
    else $error("mode 0 took protective action");
endmodule // dft_monitor

// *** hw/dft_pkg.sv ***
// Constants, register map and state type of the drive fault and trip monitor.
package dft_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_KHZ       = 50_000;
  localparam int OL_TICK_MS    = 1;
  localparam int OL_TICK_CYC   = OL_TICK_MS * CLK_KHZ;
  localparam int LOSS_UNIT_MS  = 100;
  localparam int LOSS_UNIT_CYC = LOSS_UNIT_MS * CLK_KHZ;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] REG_IN_FUNC   = 8'h00;
  localparam logic [7:0] REG_CONTACT   = 8'h04;
  localparam logic [7:0] REG_LOSS_CFG  = 8'h08;
  localparam logic [7:0] REG_WAIT_TIME = 8'h0c;
  localparam logic [7:0] REG_IN_MIN    = 8'h10;
  localparam logic [7:0] REG_RATED     = 8'h14;
  localparam logic [7:0] REG_OL_LIMIT  = 8'h18;
  localparam logic [7:0] REG_CTRL      = 8'h1c;
  localparam logic [7:0] REG_STATUS    = 8'h20;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h24;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h28;
  // ==========================================================================
  // Field layout
  localparam int FUNC_W      = 5;
  localparam int CRIT_LSB    = 0;
  localparam int MODE_LSB    = 2;
  localparam int RELAY_LSB   = 4;
  localparam int SRC_LSB     = 9;
  localparam int IMIN_LSB    = 16;
  localparam int WARN_LSB    = 16;
  localparam int CTRL_FRST   = 0;
  localparam int IRQ_EXT     = 0;
  localparam int IRQ_OL      = 1;
  localparam int IRQ_WARN    = 2;
  localparam int IRQ_LOSS    = 3;
  // ==========================================================================
  // Codes
  localparam logic [4:0] FUNC_EXT_TRIP   = 5'h04;
  localparam logic [4:0] RELAY_CMD_LOSS  = 5'h0b;
  localparam logic [1:0] CRIT_OFF        = 2'h0;
  localparam logic [1:0] CRIT_HALF       = 2'h1;
  localparam logic [1:0] CRIT_BELOW      = 2'h2;
  localparam logic [1:0] MODE_RUN        = 2'h0;
  localparam logic [1:0] MODE_FREE_RUN   = 2'h1;
  localparam logic [1:0] MODE_DECEL      = 2'h2;
  localparam logic [1:0] SRC_KEYPAD      = 2'h0;
  localparam logic [1:0] SRC_VOLT        = 2'h1;
  localparam logic [1:0] SRC_CURRENT     = 2'h2;
  localparam logic [1:0] SRC_COMM        = 2'h3;
  // ==========================================================================
  // Reset values
  localparam logic [24:0] RST_IN_FUNC   = 25'h0418820;
  localparam logic [4:0]  RST_CONTACT   = 5'h00;
  localparam logic [10:0] RST_LOSS_CFG  = 11'h110;
  localparam logic [10:0] RST_WAIT_TIME = 11'h00a;
  localparam logic [11:0] RST_IN_MIN    = 12'h000;
  localparam logic [11:0] RST_RATED     = 12'h800;
  localparam logic [15:0] RST_TRIP_LIM  = 16'h1000;
  localparam logic [15:0] RST_WARN_LIM  = 16'h0c00;
  localparam logic [3:0]  RST_IRQ_MASK  = 4'h0;
  // ==========================================================================
  // Whole state of the monitor
  typedef struct packed {
    logic [22:0] ms_cnt;
    logic [22:0] ds_cnt;
    logic [24:0] in_func;
    logic [4:0]  nc_sel;
    logic [10:0] loss_cfg;
    logic [10:0] wait_time;
    logic [11:0] vmin;
    logic [11:0] imin;
    logic [11:0] rated;
    logic [15:0] trip_lim;
    logic [15:0] warn_lim;
    logic [23:0] ol_acc;
    logic [10:0] loss_cnt;
    logic        loss_conf;
    logic        ext_trip;
    logic        ol_trip;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [31:0] rd_data;
    logic        output_off;
    logic        decel_stop;
    logic        relay_out;
    logic        warn_out;
    logic        irq;
  } dft_state_t;
endpackage

// *** verification/dft_field_model.sv ***
// Model of field contacts, analog and link command sources and the output relay.
`timescale 1ns/1ps
module dft_field_model
(
  // Clock
  input  wire logic        clk,
  // Field signals
  output logic      [4:0]  digital_in,
  output logic      [11:0] volt_input,
  output logic      [11:0] current_input,
  output logic      [11:0] drive_current,
  output logic             comm_cmd_present,
  // Relay coil
  input  wire logic        relay_out
);
  // Contacts change just after an edge, so the block sees them one edge later.
  initial
  begin
    digital_in       = 5'h00;
    volt_input       = 12'hfff;
    current_input    = 12'hfff;
    drive_current    = 12'h000;
    comm_cmd_present = 1'b1;
  end
  task automatic put_contacts(input logic [4:0] v);
    @(posedge clk);
    digital_in <= v;
  endtask
  task automatic put_cmd(input logic [11:0] v, input logic [11:0] c, input logic m);
    @(posedge clk);
    volt_input       <= v;
    current_input    <= c;
    comm_cmd_present <= m;
  endtask
  task automatic put_load(input logic [11:0] v);
    @(posedge clk);
    drive_current <= v;
  endtask
endmodule // dft_field_model

// *** verification/tb_top.sv ***
// Self-checking testbench of the drive fault and trip monitor.
`timescale 1ns/1ps
module tb_top;
  import dft_pkg::*;
  logic        clk;
  logic        rst_b;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic [4:0]  digital_in;
  logic [11:0] volt_input;
  logic [11:0] current_input;
  logic [11:0] drive_current;
  logic        comm_cmd_present;
  logic        output_off;
  logic        decel_stop;
  logic        relay_out;
  logic        warn_out;
  logic        irq;
  int          failures;
  int          num_checks;
  int          cycles;
  // ==========================================================================
  // Design and field model
  dft_monitor #(.TICK_MS_CYC(4), .TICK_DS_CYC(10)) i_dut
  (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .digital_in(digital_in), .volt_input(volt_input), .current_input(current_input),
    .drive_current(drive_current), .comm_cmd_present(comm_cmd_present), .output_off(output_off),
    .decel_stop(decel_stop), .relay_out(relay_out), .warn_out(warn_out), .irq(irq)
  );
  dft_field_model i_field
  (
    .clk(clk), .digital_in(digital_in), .volt_input(volt_input), .current_input(current_input),
    .drive_current(drive_current), .comm_cmd_present(comm_cmd_present), .relay_out(relay_out)
  );
  // ==========================================================================
  // Clock, reset and hang guard
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // The whole run is a few hundred cycles; this ceiling leaves wide margin.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  task automatic outs(input logic [2:0] exp);
    #1 chk({29'h0, output_off, decel_stop, relay_out}, {29'h0, exp});
  endtask
  task automatic conclude();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd(REG_IN_FUNC, 32'h00418820);
    rd(REG_LOSS_CFG, 32'h00000110);
    rd(REG_WAIT_TIME, 32'h0000000a);
    rd(REG_RATED, 32'h00000800);
    rd(REG_OL_LIMIT, 32'h0c001000);
    rd(REG_IRQ_MASK, 32'h00000000);
    rd(8'h2c, 32'h00000000);
    $display("test reset done");
  endtask
  task automatic t_ext_trip();
    wr(REG_IN_FUNC, 32'h00420820);
    wr(REG_IRQ_MASK, 32'h00000001);
    i_field.put_contacts(5'h08);
    repeat (3) @(posedge clk);
    chk({31'h0, output_off}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    i_field.put_contacts(5'h00);
    repeat (3) @(posedge clk);
    chk({31'h0, output_off}, 32'h1);
    wr(REG_CTRL, 32'h00000001);
    repeat (2) @(posedge clk);
    chk({31'h0, output_off}, 32'h0);
    wr(REG_IRQ_STAT, 32'h00000001);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // Terminal five is parked on another code while its contact sense is flipped.
    wr(REG_IN_FUNC, 32'h00020820);
    wr(REG_CONTACT, 32'h00000010);
    i_field.put_contacts(5'h10);
    wr(REG_IN_FUNC, 32'h00420820);
    repeat (3) @(posedge clk);
    rd(REG_STATUS, 32'h00001000);
    i_field.put_contacts(5'h00);
    repeat (3) @(posedge clk);
    chk({31'h0, output_off}, 32'h1);
    i_field.put_contacts(5'h10);
    wr(REG_CTRL, 32'h00000001);
    repeat (2) @(posedge clk);
    chk({31'h0, output_off}, 32'h0);
    // Terminal one takes the trip code while terminals two and three close on other codes.
    wr(REG_IN_FUNC, 32'h00418824);
    i_field.put_contacts(5'h17);
    repeat (3) @(posedge clk);
    rd(REG_STATUS, 32'h00001703);
    i_field.put_contacts(5'h10);
    wr(REG_CTRL, 32'h00000001);
    repeat (2) @(posedge clk);
    chk({31'h0, output_off}, 32'h0);
    $display("test ext_trip done");
  endtask
  task automatic ol_run(input logic [11:0] cur, input int lo, input int hi);
    int n;
    int w;
    n = 0;
    w = -1;
    i_field.put_load(cur);
    while (output_off !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1 n++;
      if (warn_out === 1'b1 && w < 0)
        w = n;
    end
    chk({31'h0, (n >= lo && n <= hi)}, 32'h1);
    chk({31'h0, (w > 0 && w < n)}, 32'h1);
    i_field.put_load(12'h000);
    repeat (20) @(posedge clk);
    wr(REG_CTRL, 32'h00000001);
    repeat (2) @(posedge clk);
    chk({31'h0, output_off}, 32'h0);
  endtask
  task automatic t_overload();
    wr(REG_OL_LIMIT, 32'h00080010);
    ol_run(12'h900, 56, 72);
    ol_run(12'ha00, 26, 38);
    $display("test overload done");
  endtask
  task automatic loss_case(input logic [31:0] cfg, input logic [11:0] v, input logic [11:0] c,
                           input logic m, input logic [2:0] e);
    wr(REG_LOSS_CFG, cfg);
    i_field.put_cmd(v, c, m);
    repeat (18) @(posedge clk);
    outs(3'b000);
    repeat (22) @(posedge clk);
    outs(e);
    i_field.put_cmd(12'hfff, 12'hfff, 1'b1);
    repeat (3) @(posedge clk);
    outs(3'b000);
  endtask
  task automatic t_loss();
    wr(REG_IN_MIN, 32'h01000100);
    wr(REG_WAIT_TIME, 32'h00000003);
    loss_case(32'h2b6, 12'h0ff, 12'hfff, 1'b1, 3'b101);
    loss_case(32'h2b9, 12'h090, 12'hfff, 1'b1, 3'b000);
    loss_case(32'h2b9, 12'h07f, 12'hfff, 1'b1, 3'b011);
    loss_case(32'h4b2, 12'hfff, 12'h0ff, 1'b1, 3'b001);
    loss_case(32'h714, 12'hfff, 12'hfff, 1'b0, 3'b100);
    loss_case(32'h2b4, 12'h000, 12'hfff, 1'b1, 3'b000);
    $display("test loss done");
  endtask
  // ==========================================================================
  // Main sequence
  initial
  begin
    failures   = 0;
    num_checks = 0;
    cycles     = 0;
    rst_b      = 1'b0;
    addr       = 8'h00;
    wr_data    = 32'h0;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_ext_trip();
    t_overload();
    t_loss();
    conclude();
  end
endmodule // tb_top
